// *** core/led_display_result_registers.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "led_result_regs.svh"
module led_display_result_registers
	import led_result_pkg::*;
#(
	parameter bit WIDE_VARIANT = 1'b1
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic serial_clk,
	input wire logic serial_cs_n,
	input wire logic serial_din,
	output logic serial_dout,
	output logic serial_dout_oe_n,
	input wire logic display_bypass_select,
	input wire logic display_source_select,
	input wire logic hold_enable,
	input wire logic peak_enable,
	input wire logic auto_offset_disable,
	input wire logic enhanced_offset_start,
	input wire logic conv_valid,
	input wire logic [19:0] conv_data,
	output logic auto_offset_cal_active,
	output logic enhanced_cal_run,
	output logic result_strobe,
	output logic [19:0] final_result,
	output logic [15:0] display_value,
	output logic direct_segments_active,
	output logic [15:0] seg_lit_mid,
	output logic [4:0] seg_lit_high,
	output logic sign_minus_lit,
	output logic sign_plus_lit,
	output logic lead_b_lit,
	output logic lead_c_lit
);
	logic rst_meta_n;
	logic rst_sync_n;

	reg_word_t segment_override_mid;
	logic [5:0] segment_override_high;
	reg_word_t custom_offset;
	reg_word_t result_upper;
	logic [7:0] result_lower;
	reg_word_t display_data;
	reg_word_t peak_value;

	reg_index_t access_index;
	reg_word_t read_data;
	logic write_strobe;
	reg_word_t write_data;

	logic [19:0] next_result;
	reg_word_t next_result_upper;
	logic [7:0] next_result_lower;
	logic peak_shown;
	reg_word_t mid_lit_mask;
	logic [15:0] next_seg_lit_mid;

	// Release is synchronous so no flop sees a ragged reset edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else if (clk_en) begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	serial_slave u_serial (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.clk_en(clk_en),
		.serial_clk(serial_clk),
		.serial_cs_n(serial_cs_n),
		.serial_din(serial_din),
		.serial_dout(serial_dout),
		.serial_dout_oe_n(serial_dout_oe_n),
		.access_index(access_index),
		.read_data(read_data),
		.write_strobe(write_strobe),
		.write_data(write_data)
	);

	// Segment override storage
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			segment_override_mid <= `SEG_MID_RESET;
		end else if (clk_en) begin
			if (write_strobe && access_index == `IDX_SEG_MID) begin
				segment_override_mid <= write_data & `SEG_MID_STORE_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			segment_override_high <= `SEG_HIGH_RESET;
		end else if (clk_en) begin
			if (write_strobe && access_index == `IDX_SEG_HIGH) begin
				segment_override_high <= write_data[5:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			custom_offset <= `CUSTOM_OFFSET_RESET;
		end else if (clk_en) begin
			if (write_strobe && access_index == `IDX_CUSTOM_OFFSET) begin
				custom_offset <= write_data;
			end
		end
	end

	// Offset is in upper-register units, so it lines up with bit 4
	always_comb begin
		next_result = conv_data - {custom_offset, 4'h0};
		if (WIDE_VARIANT) begin
			next_result_upper = next_result[19:4];
		end else begin
			next_result_upper = next_result[19:4] & `NARROW_DATA_MASK;
		end
		next_result_lower = {next_result[3:0], 4'h0};
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			result_upper <= `RESULT_UPPER_RESET;
			result_lower <= `RESULT_LOWER_RESET;
		end else if (clk_en) begin
			if (conv_valid) begin
				result_upper <= next_result_upper;
				result_lower <= next_result_lower;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			final_result <= 20'h00000;
			result_strobe <= 1'b0;
		end else if (clk_en) begin
			result_strobe <= conv_valid;
			if (conv_valid) begin
				final_result <= {next_result_upper, next_result[3:0]};
			end
		end
	end

	peak_tracker u_peak (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.clk_en(clk_en),
		.track_enable(peak_enable),
		.sample_valid(conv_valid),
		.sample(next_result_upper),
		.peak(peak_value)
	);

	assign peak_shown = peak_enable & ~hold_enable;

	// Host writes only land while the host owns the display source
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			display_data <= `DISPLAY_DATA_RESET;
		end else if (clk_en) begin
			if (display_source_select) begin
				if (write_strobe && access_index == `IDX_DISPLAY_DATA) begin
					if (WIDE_VARIANT) begin
						display_data <= write_data;
					end else begin
						display_data <= write_data & `NARROW_DATA_MASK;
					end
				end
			end else if (conv_valid && !hold_enable && !peak_shown) begin
				display_data <= next_result_upper;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			display_value <= `DISPLAY_DATA_RESET;
		end else if (clk_en) begin
			if (peak_shown) begin
				display_value <= peak_value;
			end else begin
				display_value <= display_data;
			end
		end
	end

	// Digit 3 and its extras only exist on the wide variant
	assign mid_lit_mask = WIDE_VARIANT ? `SEG_MID_LIT_MASK_WIDE : `SEG_MID_LIT_MASK_NARROW;

	genvar seg_bit;
	generate
		for (seg_bit = 0; seg_bit < 16; seg_bit = seg_bit + 1) begin : g_mid_seg
			always_comb begin
				next_seg_lit_mid[seg_bit] = display_bypass_select & mid_lit_mask[seg_bit]
					& ~segment_override_mid[seg_bit];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			direct_segments_active <= 1'b0;
			seg_lit_mid <= 16'h0000;
		end else if (clk_en) begin
			direct_segments_active <= display_bypass_select;
			seg_lit_mid <= next_seg_lit_mid;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			seg_lit_high <= 5'h00;
		end else if (clk_en) begin
			if (display_bypass_select && WIDE_VARIANT) begin
				seg_lit_high <= ~segment_override_high[4:0];
			end else begin
				seg_lit_high <= 5'h00;
			end
		end
	end

	// Sign is a single element: in bypass exactly one of minus or plus is lit, otherwise both are dark
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sign_minus_lit <= 1'b0;
			sign_plus_lit <= 1'b0;
		end else if (clk_en) begin
			if (display_bypass_select) begin
				sign_minus_lit <= ~segment_override_mid[`SEG_MID_SIGN_BIT];
				sign_plus_lit <= segment_override_mid[`SEG_MID_SIGN_BIT];
			end else begin
				sign_minus_lit <= 1'b0;
				sign_plus_lit <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lead_b_lit <= 1'b0;
			lead_c_lit <= 1'b0;
		end else if (clk_en) begin
			if (display_bypass_select) begin
				lead_b_lit <= ~segment_override_high[`SEG_HIGH_LEAD_BIT];
				lead_c_lit <= ~segment_override_high[`SEG_HIGH_LEAD_BIT];
			end else begin
				lead_b_lit <= 1'b0;
				lead_c_lit <= 1'b0;
			end
		end
	end

	// Result and peak registers have no write decode at all
	always_comb begin
		case (access_index)
			`IDX_SEG_MID: begin
				read_data = segment_override_mid;
			end
			`IDX_SEG_HIGH: begin
				read_data = {10'h000, segment_override_high};
			end
			`IDX_CUSTOM_OFFSET: begin
				read_data = custom_offset;
			end
			`IDX_RESULT_UPPER: begin
				read_data = result_upper;
			end
			`IDX_RESULT_LOWER: begin
				read_data = {8'h00, result_lower};
			end
			`IDX_DISPLAY_DATA: begin
				read_data = display_data;
			end
			`IDX_PEAK: begin
				read_data = peak_value;
			end
			default: begin
				read_data = 16'h0000;
			end
		endcase
	end

	// Calibration control toward the converter core
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			auto_offset_cal_active <= 1'b0;
			enhanced_cal_run <= 1'b0;
		end else if (clk_en) begin
			auto_offset_cal_active <= ~auto_offset_disable;
			enhanced_cal_run <= enhanced_offset_start;
		end
	end
endmodule
`default_nettype wire

// *** core/led_result_regs.svh ***
//
// Overview of operation
// - Bypass select drives segments from override registers
// - Stored zero lights segment, one blanks it
// - Mid override: 16-bit RW, bit0 zero
// - Sign bit zero shows minus, one plus
// - High override: 6-bit RW, reset zero
// - Leading-one bit drives B and C together
// - Final result subtracts signed custom offset
// - Upper result read-only, 16 MSBs, reset zero
// - Narrow variant uses result bits 15 to 4
// - Lower result holds four LSBs, upper nibble
// - Display data loads from result or host
// - Narrow variant display: twelve bits plus four
// - Peak register read-only, resets to negative full-scale
// - Peak copies first result, then keeps larger
// - Smaller result leaves peak unchanged
// - Clearing peak enable returns peak register to its reset value
// - Reset returns every register to default
// - Auto offset calibration while disable bit low
// - Enhanced calibration runs while start bit set
// - Source select routes host or conversion data
// - Peak enabled without hold displays peak
`ifndef LED_RESULT_REGS_SVH
`define LED_RESULT_REGS_SVH

`define IDX_SEG_MID 4'h1
`define IDX_SEG_HIGH 4'h2
`define IDX_CUSTOM_OFFSET 4'h3
`define IDX_RESULT_UPPER 4'h4
`define IDX_RESULT_LOWER 4'h5
`define IDX_DISPLAY_DATA 4'h6
`define IDX_PEAK 4'h7

`define SEG_MID_RESET 16'h0000
`define SEG_HIGH_RESET 6'h00
`define CUSTOM_OFFSET_RESET 16'h0000
`define RESULT_UPPER_RESET 16'h0000
`define RESULT_LOWER_RESET 8'h00
`define DISPLAY_DATA_RESET 16'h0000
`define PEAK_RESET 16'hB1E0

`define SEG_MID_STORE_MASK 16'hFFFE
`define SEG_MID_LIT_MASK_WIDE 16'hEFF6
`define SEG_MID_LIT_MASK_NARROW 16'h0FF6
`define SEG_MID_SIGN_BIT 12
`define SEG_HIGH_LEAD_BIT 5
`define NARROW_DATA_MASK 16'hFFF0

`define FRAME_CMD_LAST 5'h07
`define FRAME_DATA_LAST 5'h17
`define CMD_READ_BIT 7

`endif

// *** core/led_result_pkg.sv ***
package led_result_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CMD = 4'b0010,
		ST_DATA = 4'b0100,
		ST_WAIT = 4'b1000
	} serial_state_t;
	typedef logic [3:0] reg_index_t;
	typedef logic [15:0] reg_word_t;
endpackage

// *** core/serial_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "led_result_regs.svh"
module serial_slave
	import led_result_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	input wire logic clk_en,
	input wire logic serial_clk,
	input wire logic serial_cs_n,
	input wire logic serial_din,
	output logic serial_dout,
	output logic serial_dout_oe_n,
	output reg_index_t access_index,
	input wire reg_word_t read_data,
	output logic write_strobe,
	output reg_word_t write_data
);
	logic [2:0] meta;
	logic [2:0] sync;
	logic clk_prev;
	serial_state_t state;
	logic [4:0] bit_count;
	logic [15:0] rx_shift;
	logic [15:0] tx_shift;
	logic is_read;
	logic load_pending;
	logic clk_rise;
	logic clk_fall;
	assign clk_rise = sync[0] & ~clk_prev;
	assign clk_fall = ~sync[0] & clk_prev;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			meta <= 3'h6;
			sync <= 3'h6;
			clk_prev <= 1'b0;
		end else if (clk_en) begin
			meta <= {serial_din, serial_cs_n, serial_clk};
			sync <= meta;
			clk_prev <= sync[0];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
			bit_count <= 5'h00;
			rx_shift <= 16'h0000;
			tx_shift <= 16'h0000;
			is_read <= 1'b0;
			load_pending <= 1'b0;
			access_index <= 4'h0;
			write_strobe <= 1'b0;
			write_data <= 16'h0000;
			serial_dout <= 1'b0;
			serial_dout_oe_n <= 1'b1;
		end else if (clk_en) begin
			write_strobe <= 1'b0;
			load_pending <= 1'b0;
			if (sync[1]) begin
				state <= ST_IDLE;
				bit_count <= 5'h00;
				serial_dout_oe_n <= 1'b1;
			end else begin
				case (state)
					ST_IDLE: begin
						state <= ST_CMD;
					end
					ST_CMD: begin
						if (clk_rise) begin
							rx_shift <= {rx_shift[14:0], sync[2]};
							bit_count <= bit_count + 5'h01;
							if (bit_count == `FRAME_CMD_LAST) begin
								is_read <= rx_shift[`CMD_READ_BIT - 1];
								access_index <= {rx_shift[2:0], sync[2]};
								load_pending <= rx_shift[`CMD_READ_BIT - 1];
								state <= ST_DATA;
							end
						end
					end
					ST_DATA: begin
						// Read data sampled one cycle after the index settles
						// First fall re-presents bit 15 so the 9th rise still sees it
						if (load_pending) begin
							serial_dout <= read_data[15];
							tx_shift <= read_data;
							serial_dout_oe_n <= 1'b0;
						end else if (clk_fall && is_read) begin
							serial_dout <= tx_shift[15];
							tx_shift <= {tx_shift[14:0], 1'b0};
						end
						if (clk_rise) begin
							rx_shift <= {rx_shift[14:0], sync[2]};
							bit_count <= bit_count + 5'h01;
							if (bit_count == `FRAME_DATA_LAST) begin
								write_strobe <= ~is_read;
								write_data <= {rx_shift[14:0], sync[2]};
								state <= ST_WAIT;
							end
						end
					end
					ST_WAIT: begin
						if (clk_fall) begin
							serial_dout_oe_n <= 1'b1;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** core/peak_tracker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "led_result_regs.svh"
module peak_tracker
	import led_result_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	input wire logic clk_en,
	input wire logic track_enable,
	input wire logic sample_valid,
	input wire reg_word_t sample,
	output reg_word_t peak
);
	logic armed;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			peak <= `PEAK_RESET;
			armed <= 1'b0;
		end else if (clk_en) begin
			if (!track_enable) begin
				peak <= `PEAK_RESET;
				armed <= 1'b0;
			end else if (sample_valid) begin
				armed <= 1'b1;
				if (!armed) begin
					peak <= sample;
				end else if ($signed(sample) > $signed(peak)) begin
					peak <= sample;
				end
				// Equal or smaller samples fall through untouched
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/led_display_result_registers_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module led_display_result_registers_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic display_bypass_select,
	input wire logic auto_offset_disable,
	input wire logic enhanced_offset_start,
	input wire logic conv_valid,
	input wire logic [19:0] conv_data,
	input wire logic auto_offset_cal_active,
	input wire logic enhanced_cal_run,
	input wire logic result_strobe,
	input wire logic [19:0] final_result,
	input wire logic direct_segments_active,
	input wire logic [15:0] seg_lit_mid,
	input wire logic [4:0] seg_lit_high,
	input wire logic sign_minus_lit,
	input wire logic sign_plus_lit,
	input wire logic lead_b_lit,
	input wire logic lead_c_lit
);
	logic [2:0] up_cnt;
	logic live;
	// Internal reset leaves through two flops, so skip the first edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt <= 3'h0;
		end else if (clk_en && up_cnt != 3'h6) begin
			up_cnt <= up_cnt + 3'h1;
		end
	end
	assign live = (up_cnt == 3'h6);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_taken;
		live && clk_en && conv_valid;
	endsequence
	sequence s_answer;
		result_strobe;
	endsequence
	a_strobe_follows_conv: assert property (s_taken |=> s_answer)
		else $error("result strobe missing after conversion");
	a_low_nibble_kept: assert property (s_taken |=> final_result[3:0] == $past(conv_data[3:0]))
		else $error("low result nibble wrong");
	a_strobe_has_cause: assert property (live and s_answer |-> $past(conv_valid))
		else $error("result strobe without conversion");
	a_bypass_copy: assert property (live |-> direct_segments_active == $past(display_bypass_select))
		else $error("direct segment mode not following select");
	a_dark_unbypassed: assert property (!direct_segments_active |-> seg_lit_mid == 16'h0000
		&& seg_lit_high == 5'h00 && !sign_minus_lit && !sign_plus_lit && !lead_b_lit)
		else $error("segments lit outside bypass");
	a_sign_exclusive: assert property (direct_segments_active |-> sign_minus_lit ^ sign_plus_lit)
		else $error("sign segments not exclusive");
	a_lead_pair: assert property (lead_b_lit == lead_c_lit)
		else $error("leading B and C differ");
	a_fixed_bits_dark: assert property ((seg_lit_mid & 16'h1009) == 16'h0000)
		else $error("unused mid segment bit lit");
	a_auto_cal_follow: assert property (live |-> auto_offset_cal_active == !$past(auto_offset_disable))
		else $error("auto calibration state wrong");
	a_enh_cal_follow: assert property (live |-> enhanced_cal_run == $past(enhanced_offset_start))
		else $error("enhanced calibration state wrong");
endmodule
`default_nettype wire

// *** bench/host_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_master (
	input wire logic sys_clk,
	output logic serial_clk,
	output logic serial_cs_n,
	output logic serial_din,
	input wire logic serial_dout,
	input wire logic serial_dout_oe_n
);
	logic [23:0] frame;
	initial begin
		serial_clk = 1'b0;
		serial_cs_n = 1'b1;
		serial_din = 1'b0;
	end
	// 160 ns bit time; clock idles low, data flips away from its last bit
	task automatic xfer(input logic rd, input logic [3:0] idx, input logic [15:0] wdata,
		output logic [15:0] rdata);
		frame = {rd, 3'b000, idx, wdata};
		rdata = 16'h0000;
		@(posedge sys_clk);
		#1 serial_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			repeat (10) @(posedge sys_clk);
			#1 serial_clk = 1'b0;
			serial_din = frame[i];
			repeat (10) @(posedge sys_clk);
			if (i < 16) begin
				rdata[i] = serial_dout_oe_n ? ~serial_dout : serial_dout;
			end
			#1 serial_clk = 1'b1;
		end
		repeat (10) @(posedge sys_clk);
		#1 serial_clk = 1'b0;
		serial_din = ~serial_din;
		repeat (10) @(posedge sys_clk);
		#1 serial_cs_n = 1'b1;
		repeat (6) @(posedge sys_clk);
		// Return off the edge so the caller's next drive cannot race the design
		#1;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk, rst_n, serial_clk, serial_cs_n, serial_din, serial_dout, serial_dout_oe_n;
	logic display_bypass_select, display_source_select, hold_enable, peak_enable;
	logic auto_offset_disable, enhanced_offset_start, conv_valid, result_strobe;
	logic auto_offset_cal_active, enhanced_cal_run, direct_segments_active;
	logic sign_minus_lit, sign_plus_lit, lead_b_lit, lead_c_lit;
	logic [19:0] conv_data, final_result, last_e;
	logic [15:0] display_value, seg_lit_mid, offset_v, v, w, r;
	logic [4:0] seg_lit_high;
	logic [31:0] rng = 32'h0000005D;
	logic [19:0] exp_q[$];
	logic [3:0] ids[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
	int mismatches = 0, tests_run = 0, cycles = 0;
	led_display_result_registers #(.WIDE_VARIANT(1'b1)) i_dut (.sys_clk, .rst_n, .clk_en(1'b1),
		.serial_clk, .serial_cs_n, .serial_din, .serial_dout, .serial_dout_oe_n,
		.display_bypass_select, .display_source_select, .hold_enable, .peak_enable,
		.auto_offset_disable, .enhanced_offset_start, .conv_valid, .conv_data,
		.auto_offset_cal_active, .enhanced_cal_run, .result_strobe, .final_result, .display_value,
		.direct_segments_active, .seg_lit_mid, .seg_lit_high, .sign_minus_lit, .sign_plus_lit,
		.lead_b_lit, .lead_c_lit);
	host_master i_host (.sys_clk, .serial_clk, .serial_cs_n, .serial_din, .serial_dout,
		.serial_dout_oe_n);
	function logic [15:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[15:0];
	endfunction
	task chk(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] idx, input logic [15:0] d);
		logic [15:0] unused;
		i_host.xfer(1'b0, idx, d, unused);
	endtask
	task rdc(input logic [3:0] idx, input logic [15:0] exp);
		logic [15:0] got;
		i_host.xfer(1'b1, idx, 16'h0000, got);
		chk({4'h0, got}, {4'h0, exp});
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task conv(input logic [19:0] d);
		tick(1);
		conv_valid = 1'b1;
		conv_data = d;
		last_e = d - {offset_v, 4'h0};
		exp_q.push_back(last_e);
		tick(1);
		conv_valid = 1'b0;
		conv_data = ~d;
		tick(3);
	endtask
	task done(input string name);
		$display("test %s finished", name);
	endtask
	task end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_of_test();
		end
	end
	// Results are checked in arrival order, however far apart they come
	always @(negedge sys_clk) begin
		if (result_strobe === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(final_result, ~final_result);
			end else begin
				chk(final_result, exp_q.pop_front());
			end
		end
	end
	initial begin
		{rst_n, display_bypass_select, display_source_select, hold_enable, peak_enable} = 5'h00;
		{auto_offset_disable, enhanced_offset_start, conv_valid} = 3'h0;
		conv_data = 20'h00000;
		offset_v = 16'h0000;
		tick(12);
		rst_n = 1'b1;
		tick(8);
		for (int i = 0; i < 8; i++) rdc(ids[i], (i == 6) ? 16'hB1E0 : 16'h0000);
		done("reset");
		v = rnd();
		w = rnd();
		for (int k = 0; k < 2; k++) begin
			wr(4'h1, v);
			wr(4'h2, w);
			rdc(4'h1, v & 16'hFFFE);
			rdc(4'h2, w & 16'h003F);
			display_bypass_select = 1'b1;
			tick(3);
			chk(seg_lit_mid, ~v & 16'hEFF6);
			chk(sign_minus_lit, {~v[12]});
			chk(sign_plus_lit, v[12]);
			chk(seg_lit_high, {~w[4:0]});
			chk(lead_b_lit, {~w[5]});
			chk(lead_c_lit, {~w[5]});
			display_bypass_select = 1'b0;
			v = ~v;
			w = ~w;
		end
		wr(4'h4, v);
		wr(4'h7, v);
		rdc(4'h4, 16'h0000);
		rdc(4'h7, 16'hB1E0);
		done("segments");
		offset_v = rnd();
		wr(4'h3, offset_v);
		rdc(4'h3, offset_v);
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			conv({rnd(), r[3:0]});
		end
		chk(display_value, last_e[19:4]);
		rdc(4'h4, last_e[19:4]);
		rdc(4'h5, {8'h00, last_e[3:0], 4'h0});
		v = rnd();
		wr(4'h6, v);
		rdc(4'h6, last_e[19:4]);
		display_source_select = 1'b1;
		wr(4'h6, v);
		rdc(4'h6, v);
		conv({rnd(), 4'h3});
		chk(display_value, v);
		display_source_select = 1'b0;
		hold_enable = 1'b1;
		conv({rnd(), 4'hC});
		chk(display_value, v);
		hold_enable = 1'b0;
		done("results");
		wr(4'h3, 16'h0000);
		offset_v = 16'h0000;
		peak_enable = 1'b1;
		conv({16'h0010, 4'h0});
		rdc(4'h7, 16'h0010);
		chk(display_value, 16'h0010);
		conv({16'hFFF0, 4'h0});
		rdc(4'h7, 16'h0010);
		conv({16'h0100, 4'h5});
		rdc(4'h7, 16'h0100);
		peak_enable = 1'b0;
		tick(3);
		rdc(4'h7, 16'hB1E0);
		done("peak");
		// Reference has long settled by now, so calibration may start
		for (int k = 0; k < 2; k++) begin
			auto_offset_disable = k[0];
			enhanced_offset_start = !k[0];
			tick(2);
			chk(auto_offset_cal_active, !auto_offset_disable);
			chk(enhanced_cal_run, enhanced_offset_start);
		end
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(8);
		rdc(4'h3, 16'h0000);
		done("calibration and reset");
		end_of_test();
	end
endmodule
bind led_display_result_registers led_display_result_registers_props i_props (.sys_clk, .rst_n,
	.clk_en, .display_bypass_select, .auto_offset_disable, .enhanced_offset_start, .conv_valid,
	.conv_data, .auto_offset_cal_active, .enhanced_cal_run, .result_strobe, .final_result,
	.direct_segments_active, .seg_lit_mid, .seg_lit_high, .sign_minus_lit, .sign_plus_lit,
	.lead_b_lit, .lead_c_lit);
`default_nettype wire
